// ### bench/icgc_ctrl_properties.sv
// Port-level properties of the clock generator control block.
// Assumes it is bound to icgc_ctrl and sees only that module's ports.
`include "icgc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module icgc_ctrl_checker #(
  parameter STAB_CYCLES = 4096,
  parameter STAB_CW = 13
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Mode inputs
  input wire logic stopMode,
  input wire logic stopOscillatorEnable,
  // Generator controls
  input wire logic monitorIrq,
  input wire logic oscOutSelectExternal,
  input wire logic internalGenOn,
  input wire logic externalGenOn,
  input wire logic monitorOn,
  input wire logic [6:0] multiplierUsed,
  input wire logic [7:0] trimFactor,
  input wire logic [3:0] dividerUsed,
  input wire logic clocksRun
);
  // ************************************
  // Properties, all on mclk
  // ************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Two idle cycles allow for the irq output lagging its sources
  chk_irq_needs_mon: assert property (
    !monitorOn ##1 !monitorOn |=> !monitorIrq)
    else $error("irq active with monitor off");
  chk_mon_needs_gens: assert property (
    monitorOn |-> internalGenOn && externalGenOn)
    else $error("monitor on with a generator off");
  chk_int_forced_on: assert property (
    !oscOutSelectExternal |=> internalGenOn)
    else $error("internal generator off under internal select");
  chk_ext_forced_on: assert property (
    (oscOutSelectExternal || monitorOn) |=> externalGenOn)
    else $error("external generator off while needed");
  chk_mult_locked: assert property (
    monitorOn && regWrite && regAddr == `ICGC_ADDR_MULT
    |=> $stable(multiplierUsed))
    else $error("multiplier changed while monitoring");
  chk_trim_locked: assert property (
    monitorOn && regWrite && regAddr == `ICGC_ADDR_TRIM
    |=> $stable(trimFactor))
    else $error("trim changed while monitoring");
  chk_mult_zero_one: assert property (
    !monitorOn && regWrite && regAddr == `ICGC_ADDR_MULT &&
    regWrData[6:0] == 7'h00 |=> multiplierUsed == `ICGC_MULT_MIN)
    else $error("zero multiplier not taken as one");
  chk_div_clamp: assert property (dividerUsed <= `ICGC_DIV_MAX)
    else $error("divider above nine");
  chk_stop_halts: assert property (
    stopMode && !stopOscillatorEnable |=> !clocksRun)
    else $error("clocks run in stop");
  chk_read_idle: assert property (
    !regRead |=> regRdData == `ICGC_READ_IDLE)
    else $error("read data outside its cycle");
endmodule
bind icgc_ctrl icgc_ctrl_checker #(.STAB_CYCLES(STAB_CYCLES),
  .STAB_CW(STAB_CW)) u_chk (.mclk(mclk), .reset_n(reset_n),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .stopMode(stopMode),
  .stopOscillatorEnable(stopOscillatorEnable), .monitorIrq(monitorIrq),
  .oscOutSelectExternal(oscOutSelectExternal),
  .internalGenOn(internalGenOn), .externalGenOn(externalGenOn),
  .monitorOn(monitorOn), .multiplierUsed(multiplierUsed),
  .trimFactor(trimFactor), .dividerUsed(dividerUsed),
  .clocksRun(clocksRun));
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the clock generator control block.
// Assumes icgc_ctrl and the checker are compiled with this file.
`include "icgc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] aCtl = `ICGC_ADDR_CTRL;
  localparam logic [15:0] aMul = `ICGC_ADDR_MULT;
  localparam logic [15:0] aTrm = `ICGC_ADDR_TRIM;
  // Bench-driven inputs
  logic mclk, reset_n, regWrite, regRead, extRun, extDiv;
  logic [15:0] regAddr;
  logic [7:0] regWrData, loopOscillatorStages;
  logic internalClockDead, externalClockDead, internalLocked, externalClock;
  logic stopMode, stopOscillatorEnable;
  logic [3:0] loopDividerStages;
  // Design outputs
  wire [7:0] regRdData, trimFactor, oscillatorStages;
  wire monitorIrq, oscOutSelectExternal, internalGenOn, externalGenOn;
  wire monitorOn, clocksRun;
  wire [6:0] multiplierUsed;
  wire [3:0] dividerUsed;
  int errTotal, totalChecks, cyc;
  // Short stabilisation count keeps the run brief
  icgc_ctrl #(.STAB_CYCLES(8), .STAB_CW(4)) i_dut (.mclk(mclk),
    .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .internalClockDead(internalClockDead),
    .externalClockDead(externalClockDead),
    .internalLocked(internalLocked), .externalClock(externalClock),
    .stopMode(stopMode), .stopOscillatorEnable(stopOscillatorEnable),
    .loopDividerStages(loopDividerStages),
    .loopOscillatorStages(loopOscillatorStages),
    .trimStore5v(8'h5A), .trimStore3v(8'hC3), .monitorIrq(monitorIrq),
    .oscOutSelectExternal(oscOutSelectExternal),
    .internalGenOn(internalGenOn), .externalGenOn(externalGenOn),
    .monitorOn(monitorOn), .multiplierUsed(multiplierUsed),
    .trimFactor(trimFactor), .dividerUsed(dividerUsed),
    .oscillatorStages(oscillatorStages), .clocksRun(clocksRun));
  // ************************************
  // Clock, external clock and timeout
  // ************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // External clock runs at a quarter rate, and only when enabled
  always @(posedge mclk) begin
    extDiv <= ~extDiv;
    if (extRun && extDiv) externalClock <= ~externalClock;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errTotal++;
      conclude();
    end
  end
  // ************************************
  // Shared tasks
  // ************************************
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    totalChecks++;
    if (s !== e) begin
      errTotal++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input string n, input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk(n, regRdData, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ************************************
  // Test sequence
  // ************************************
  initial begin
    {regWrite, regRead, extRun, extDiv, externalClock} = 5'h00;
    {internalClockDead, externalClockDead, internalLocked} = 3'h0;
    {stopMode, stopOscillatorEnable, regAddr, regWrData} = 26'h0;
    {errTotal, totalChecks, cyc} = 0;
    loopDividerStages = 4'hC;
    loopOscillatorStages = 8'hA5;
    reset_n = 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values, stores, unmapped place, loop-driven fields
    rdc("ctrl", aCtl, 8'h08);
    rdc("mult", aMul, 8'h15);
    rdc("trim", aTrm, 8'h80);
    rdc("store5", `ICGC_ADDR_TRIM5V, 8'h5A);
    rdc("store3", `ICGC_ADDR_TRIM3V, 8'hC3);
    rdc("unmapped", 16'h0040, 8'h00);
    chk("clocksRun", clocksRun, 8'h01);
    chk("divUsed", dividerUsed, 8'h09);
    wr(`ICGC_ADDR_STAGE, 8'h55);
    chk("stages", oscillatorStages, 8'hA5);
    @(posedge mclk) loopDividerStages <= 4'h3;
    idle(3);
    chk("divLoop", dividerUsed, 8'h03);
    $display("test reset done");
    wr(aMul, 8'h00);
    chk("multUsed", multiplierUsed, 8'h01);
    wr(aTrm, 8'h7F);
    chk("trimFactor", trimFactor, 8'h7F);
    $display("test settings done");
    // Select refused before the external path is stable
    @(posedge mclk) internalLocked <= 1'b1;
    idle(4);
    wr(aCtl, 8'h0A);
    wr(aCtl, 8'h1A);
    rdc("selRefused", aCtl, 8'h0E);
    @(posedge mclk) extRun <= 1'b1;
    idle(60);
    rdc("extStable", aCtl, 8'h0F);
    wr(aCtl, 8'h1A);
    rdc("selExt", aCtl, 8'h1F);
    chk("oscSel", oscOutSelectExternal, 8'h01);
    wr(aCtl, 8'h12);
    chk("intOff", internalGenOn, 8'h00);
    wr(aCtl, 8'h10);
    rdc("extHeld", aCtl, 8'h13);
    chk("extOnPin", externalGenOn, 8'h01);
    // Divider and stage take writes while the internal generator is off
    wr(`ICGC_ADDR_DIV, 8'h0C);
    chk("divClamp", dividerUsed, 8'h09);
    wr(`ICGC_ADDR_STAGE, 8'h55);
    chk("stageWr", oscillatorStages, 8'h55);
    rdc("divRaw", `ICGC_ADDR_DIV, 8'h0C);
    rdc("stageRd", `ICGC_ADDR_STAGE, 8'h55);
    wr(aCtl, 8'h1A);
    idle(4);
    rdc("intBack", aCtl, 8'h1F);
    $display("test select done");
    // Irq enable refused in the cycle the monitor turns on
    wr(aCtl, 8'hBA);
    rdc("monOn", aCtl, 8'h3F);
    chk("monOnPin", monitorOn, 8'h01);
    wr(aCtl, 8'hBA);
    rdc("irqEn", aCtl, 8'hBF);
    wr(aMul, 8'h15);
    chk("multLock", multiplierUsed, 8'h01);
    wr(aTrm, 8'h80);
    chk("trimLock", trimFactor, 8'h7F);
    // Dead internal clock sets the flag; unarmed zero keeps it
    @(posedge mclk) internalClockDead <= 1'b1;
    idle(6);
    chk("irqSet", monitorIrq, 8'h01);
    @(posedge mclk) internalClockDead <= 1'b0;
    wr(aCtl, 8'h9A);
    idle(6);
    chk("irqKept", monitorIrq, 8'h01);
    rdc("flagHeld", aCtl, 8'hFF);
    wr(aCtl, 8'hBA);
    rdc("flagClr", aCtl, 8'hBF);
    chk("irqClr", monitorIrq, 8'h00);
    wr(aCtl, 8'h1A);
    rdc("monOff", aCtl, 8'h1F);
    $display("test monitor done");
    // Stop without the oscillator enable kills monitor and stables
    wr(aCtl, 8'h3A);
    @(posedge mclk) stopMode <= 1'b1;
    idle(4);
    chk("stopRun", clocksRun, 8'h00);
    rdc("stopCtl", aCtl, 8'h1A);
    @(posedge mclk) stopOscillatorEnable <= 1'b1;
    idle(3);
    chk("stopOsc", clocksRun, 8'h01);
    @(posedge mclk) stopMode <= 1'b0;
    $display("test stop done");
    // Lost external clock forces the internal select and drops stable
    @(posedge mclk) externalClockDead <= 1'b1;
    idle(4);
    rdc("extLost", aCtl, 8'h0E);
    chk("oscSelInt", oscOutSelectExternal, 8'h00);
    $display("test external loss done");
    conclude();
  end
endmodule
`default_nettype wire

// ### hw/icgc_ctrl.v
// Register control of an on-chip clock generator: interlocks between the
// generator enables, stable flags, clock select and the clock monitor,
// plus multiplier, trim, divider and stage settings.
// Assumes a single-cycle register port on mclk, monitor and lock levels
// from the analog side, and loop filter values on mclk.
//
// Local design decision: the plain strobed port.
`include "icgc_map.vh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// RQ1: Interrupt when enable and flag both set
// RQ2: Irq enable settable after monitor on; else cleared
// RQ3: Monitor flags dead internal or external clock
// RQ4: Flag clears by read then zero write
// RQ5: Monitor on needs both generators on, stable
// RQ6: Monitor held by flag; cleared by off/stop
// RQ7: Select picks external clock when one
// RQ8: Select change needs target clock on, stable
// RQ9: Select forced by dead or disabled clock
// RQ10: Internal off needs select one, monitor off
// RQ11: Internal stable cleared by loss or writes
// RQ12: External off needs select, monitor off
// RQ13: External stable after 4096 external edges
// RQ14: Multiplier zero acts as one; reset 21
// RQ15: Multiplier and trim locked while monitoring
// RQ16: Trim step tunes frequency; reset midpoint
// RQ17: Divider clamps at nine, loop driven
// RQ18: Stage count loop driven, writes ignored then
// RQ19: Stop without oscillator enable halts clocks
// RQ20: Flag ignores ones and unarmed zeros
// RQ21: Stored trim values readable by software
module icgc_ctrl #(
  parameter STAB_CYCLES = `ICGC_STAB_CYCLES,
  parameter STAB_CW = 13
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Register port
  input wire [15:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  // Analog monitor and oscillator status, asynchronous
  input wire internalClockDead,
  input wire externalClockDead,
  input wire internalLocked,
  input wire externalClock,
  // System mode and configuration, on mclk
  input wire stopMode,
  input wire stopOscillatorEnable,
  // Loop filter values, on mclk
  input wire [3:0] loopDividerStages,
  input wire [7:0] loopOscillatorStages,
  // Non-volatile trim storage, on mclk
  input wire [7:0] trimStore5v,
  input wire [7:0] trimStore3v,
  // Generator controls
  output reg monitorIrq,
  output reg oscOutSelectExternal,
  output reg internalGenOn,
  output reg externalGenOn,
  output reg monitorOn,
  output reg [6:0] multiplierUsed,
  output reg [7:0] trimFactor,
  output reg [3:0] dividerUsed,
  output reg [7:0] oscillatorStages,
  output reg clocksRun
);
  // ********************************************
  // Synchronised analog inputs
  // ********************************************
  wire [3:0] syncLevels;
  wire intDead = syncLevels[0];
  wire extDead = syncLevels[1];
  wire intLock = syncLevels[2];
  wire extClkSync = syncLevels[3];

  // Monitor and lock levels come from other clocks
  icgc_sync #(
    .WIDTH(4)
  ) levelSync (
    .mclk(mclk),
    .reset_n(reset_n),
    .asyncIn({externalClock, internalLocked, externalClockDead,
      internalClockDead}),
    .syncOut(syncLevels)
  );

  // ********************************************
  // State
  // ********************************************
  reg monitorIrqEnable; // Monitor interrupt enable
  reg monitorFlag; // Sticky dead clock flag
  reg clockSelect; // One selects the external clock
  reg internalStable; // Internal clock near target
  wire externalStable; // External startup done
  reg [6:0] multiplierFactor; // Raw multiplier as written
  reg [3:0] dividerStages; // Raw divider value
  reg flagArmed; // Flag was read while set
  // Condition history, one bus cycle back
  reg monReadyPrev;
  reg extReadyPrev;
  reg intReadyPrev;
  reg intOffOkPrev;
  reg extOffOkPrev;

  // ********************************************
  // Decode
  // ********************************************
  wire wrCtrl = regWrite && (regAddr == `ICGC_ADDR_CTRL);
  wire wrMult = regWrite && (regAddr == `ICGC_ADDR_MULT);
  wire wrTrim = regWrite && (regAddr == `ICGC_ADDR_TRIM);
  wire wrDiv = regWrite && (regAddr == `ICGC_ADDR_DIV);
  wire wrStage = regWrite && (regAddr == `ICGC_ADDR_STAGE);
  wire rdCtrl = regRead && (regAddr == `ICGC_ADDR_CTRL);
  // Stop without the oscillator enable kills generation
  wire stopKill = stopMode && !stopOscillatorEnable;

  // Present-cycle readiness conditions
  wire monReady = internalGenOn && externalGenOn && internalStable &&
    externalStable;
  wire extReady = externalGenOn && externalStable;
  wire intReady = internalGenOn && internalStable;
  wire intOffOk = clockSelect && !monitorOn;
  wire extOffOk = !clockSelect && !monitorOn;

  // ********************************************
  // Next values of control bits
  // ********************************************
  reg next_monitorOn;
  reg next_monitorFlag;
  reg next_monitorIrqEnable;
  reg next_clockSelect;
  reg next_internalGenOn;
  reg next_externalGenOn;
  reg next_internalStable;

  // Writes first, then forcing conditions in rising priority
  always @* begin
    // Monitor on
    next_monitorOn = monitorOn;
    if (wrCtrl) begin
      if (!regWrData[`ICGC_BIT_MONON])
        next_monitorOn = 1'b0;
      else if (monReady && monReadyPrev)
        next_monitorOn = 1'b1; // [RQ5]
    end
    // Held so a pending flag cannot be lost
    if (monitorFlag)
      next_monitorOn = 1'b1; // [RQ6]
    if (!internalGenOn || !externalGenOn || stopKill)
      next_monitorOn = 1'b0; // [RQ6]

    // Monitor flag: cleared by an armed zero write, or with the monitor off or in stop
    next_monitorFlag = monitorFlag;
    if (wrCtrl && !regWrData[`ICGC_BIT_FLAG] && flagArmed)
      next_monitorFlag = 1'b0; // [RQ4] [RQ20]
    // Detection wins over a write clear in the same cycle
    if (monitorOn && (intDead || extDead))
      next_monitorFlag = 1'b1; // [RQ3]
    if (!monitorOn || stopKill)
      next_monitorFlag = 1'b0; // [RQ4]

    // Interrupt enable
    next_monitorIrqEnable = monitorIrqEnable;
    if (wrCtrl) begin
      if (!regWrData[`ICGC_BIT_IRQEN])
        next_monitorIrqEnable = 1'b0;
      else if (monitorOn)
        next_monitorIrqEnable = 1'b1; // [RQ2]
    end
    if (!monitorOn || stopKill)
      next_monitorIrqEnable = 1'b0; // [RQ2]

    // Clock select
    next_clockSelect = clockSelect;
    if (wrCtrl) begin
      if (regWrData[`ICGC_BIT_CSEL] && extReady && extReadyPrev)
        next_clockSelect = 1'b1; // [RQ8]
      else if (!regWrData[`ICGC_BIT_CSEL] && intReady && intReadyPrev)
        next_clockSelect = 1'b0; // [RQ8]
    end
    if (intDead || !internalGenOn)
      next_clockSelect = 1'b1; // [RQ9]
    // A lost external clock is the worse case, so it wins
    if (extDead || !externalGenOn)
      next_clockSelect = 1'b0; // [RQ9]

    // Internal generator on
    next_internalGenOn = internalGenOn;
    if (wrCtrl) begin
      if (regWrData[`ICGC_BIT_INTON])
        next_internalGenOn = 1'b1;
      else if (intOffOk && intOffOkPrev)
        next_internalGenOn = 1'b0; // [RQ10]
    end
    if (monitorOn || !clockSelect)
      next_internalGenOn = 1'b1; // [RQ10]

    // External generator on
    next_externalGenOn = externalGenOn;
    if (wrCtrl) begin
      if (regWrData[`ICGC_BIT_EXTON])
        next_externalGenOn = 1'b1;
      else if (extOffOk && extOffOkPrev)
        next_externalGenOn = 1'b0; // [RQ12]
    end
    if (clockSelect || monitorOn)
      next_externalGenOn = 1'b1; // [RQ12]

    // Internal stable follows lock, dropped by any retune
    next_internalStable = intLock && internalGenOn && !intDead &&
      !stopKill && !wrMult && !wrTrim; // [RQ11]
  end

  // ********************************************
  // External startup counter
  // ********************************************
  // Restarts whenever the path is off, lost or stopped
  icgc_ext_stab #(
    .STAB_CYCLES(STAB_CYCLES),
    .CW(STAB_CW)
  ) extStab (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(externalGenOn && !extDead && !stopKill), // [RQ13]
    .extClkSync(extClkSync),
    .stable(externalStable)
  );

  // ********************************************
  // Control register update
  // ********************************************
  // Reset loads the power-up defaults
  always @(posedge mclk) begin
    if (!reset_n) begin
      monitorOn <= 1'b0;
      monitorFlag <= 1'b0;
      monitorIrqEnable <= 1'b0;
      clockSelect <= 1'b0;
      internalGenOn <= 1'b1;
      externalGenOn <= 1'b0;
      internalStable <= 1'b0;
      monitorIrq <= 1'b0;
      oscOutSelectExternal <= 1'b0;
      clocksRun <= 1'b1;
      monReadyPrev <= 1'b0;
      extReadyPrev <= 1'b0;
      intReadyPrev <= 1'b0;
      intOffOkPrev <= 1'b0;
      extOffOkPrev <= 1'b0;
    end else begin
      monitorOn <= next_monitorOn;
      monitorFlag <= next_monitorFlag;
      monitorIrqEnable <= next_monitorIrqEnable;
      clockSelect <= next_clockSelect;
      internalGenOn <= next_internalGenOn;
      externalGenOn <= next_externalGenOn;
      internalStable <= next_internalStable;
      // Request stands while both bits stand
      monitorIrq <= next_monitorIrqEnable && next_monitorFlag; // [RQ1]
      // Drives the output clock mux
      oscOutSelectExternal <= next_clockSelect; // [RQ7]
      // Gates output, oscillator and timebase clocks low
      clocksRun <= !stopKill; // [RQ19]
      // History gives the "stood for a bus cycle" qualifiers
      monReadyPrev <= monReady;
      extReadyPrev <= extReady;
      intReadyPrev <= intReady;
      intOffOkPrev <= intOffOk;
      extOffOkPrev <= extOffOk;
    end
  end

  // ********************************************
  // Flag clear arming
  // ********************************************
  // A read that sees the flag set arms one later zero write
  always @(posedge mclk) begin
    if (!reset_n) begin
      flagArmed <= 1'b0;
    end else if (rdCtrl && monitorFlag) begin
      flagArmed <= 1'b1; // [RQ4]
    end else if (wrCtrl || !monitorFlag) begin
      // Any control register write spends the arming
      flagArmed <= 1'b0; // [RQ20]
    end
  end

  // ********************************************
  // Multiplier and trim
  // ********************************************
  // Frozen while the monitor watches the clocks
  always @(posedge mclk) begin
    if (!reset_n) begin
      multiplierFactor <= `ICGC_MULT_RESET; // [RQ14]
      multiplierUsed <= `ICGC_MULT_RESET;
      trimFactor <= `ICGC_TRIM_RESET; // [RQ16]
    end else begin
      if (wrMult && !monitorOn) begin
        multiplierFactor <= regWrData[6:0]; // [RQ15]
        // Zero would stop the oscillator, so it runs as one
        if (regWrData[6:0] == 7'h00)
          multiplierUsed <= `ICGC_MULT_MIN; // [RQ14]
        else
          multiplierUsed <= regWrData[6:0];
      end
      // Higher trim lowers frequency in the analog core
      if (wrTrim && !monitorOn)
        trimFactor <= regWrData; // [RQ15] [RQ16]
    end
  end

  // ********************************************
  // Divider and stage counts
  // ********************************************
  // The loop runs through reset, so its value is taken then too
  wire loopDrives = !reset_n || internalGenOn;
  // Raw divider source, and its clamped copy for the analog core
  wire [3:0] divIn = loopDrives ? loopDividerStages : regWrData[3:0];
  wire [3:0] divClamped = (divIn > `ICGC_DIV_MAX) ? `ICGC_DIV_MAX : divIn;

  // Writes land only while the internal generator is off
  always @(posedge mclk) begin
    if (loopDrives) begin
      dividerStages <= loopDividerStages; // [RQ17]
      dividerUsed <= divClamped; // [RQ17]
      oscillatorStages <= loopOscillatorStages; // [RQ18]
    end else begin
      if (wrDiv) begin
        dividerStages <= regWrData[3:0];
        dividerUsed <= divClamped; // [RQ17]
      end
      if (wrStage)
        oscillatorStages <= regWrData;
    end
  end

  // ********************************************
  // Read data
  // ********************************************
  // Control byte in its field order
  wire [7:0] ctrlByte = {monitorIrqEnable, monitorFlag, monitorOn,
    clockSelect, internalGenOn, internalStable, externalGenOn,
    externalStable};

  // Data stand for exactly the cycle after the read strobe
  always @(posedge mclk) begin
    if (!reset_n) begin
      regRdData <= `ICGC_READ_IDLE;
    end else if (regRead) begin
      case (regAddr)
        `ICGC_ADDR_CTRL: regRdData <= ctrlByte;
        `ICGC_ADDR_MULT: regRdData <= {1'b0, multiplierFactor};
        `ICGC_ADDR_TRIM: regRdData <= trimFactor;
        `ICGC_ADDR_DIV: regRdData <= {4'h0, dividerStages};
        `ICGC_ADDR_STAGE: regRdData <= oscillatorStages;
        `ICGC_ADDR_TRIM5V: regRdData <= trimStore5v; // [RQ21]
        `ICGC_ADDR_TRIM3V: regRdData <= trimStore3v; // [RQ21]
        default: regRdData <= `ICGC_READ_IDLE;
      endcase
    end else begin
      regRdData <= `ICGC_READ_IDLE;
    end
  end
endmodule
`default_nettype wire

// ### hw/icgc_ext_stab.v
// Startup counter for the external clock path.
// Assumes the external clock level arrives already synchronised.
`timescale 1ns/1ps
`default_nettype none
module icgc_ext_stab #(
  parameter STAB_CYCLES = 4096,
  parameter CW = 13
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Control
  input wire enable,
  input wire extClkSync,
  // Status
  output reg stable
);
  // Last seen external level, for rising edge detection
  reg lastLevel;
  // External edges counted since enable
  reg [CW-1:0] edgeCount;
  wire risingEdge = extClkSync & ~lastLevel;

  // Counter restarts whenever the path is disabled or lost
  always @(posedge mclk) begin
    if (!reset_n) begin
      lastLevel <= 1'b0;
      edgeCount <= {CW{1'b0}};
      stable <= 1'b0;
    end else begin
      lastLevel <= extClkSync;
      if (!enable) begin
        edgeCount <= {CW{1'b0}};
        stable <= 1'b0;
      end else if (risingEdge && !stable) begin
        // Saturates once the startup count is reached
        if (edgeCount == STAB_CYCLES[CW-1:0] - 1'b1)
          stable <= 1'b1;
        edgeCount <= edgeCount + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/icgc_map.vh
// Constants for the clock generator control block: addresses, fields,
// reset values and counts.
// Assumes an 8-bit register port with a 16-bit address.
`ifndef ICGC_MAP_VH
`define ICGC_MAP_VH
// ********************************************
// Register addresses
// ********************************************
`define ICGC_ADDR_CTRL 16'h0036
`define ICGC_ADDR_MULT 16'h0037
`define ICGC_ADDR_TRIM 16'h0038
`define ICGC_ADDR_DIV 16'h0039
`define ICGC_ADDR_STAGE 16'h003A
`define ICGC_ADDR_TRIM5V 16'hFF80
`define ICGC_ADDR_TRIM3V 16'hFF81
// ********************************************
// Control and status register fields
// ********************************************
`define ICGC_BIT_IRQEN 7
`define ICGC_BIT_FLAG 6
`define ICGC_BIT_MONON 5
`define ICGC_BIT_CSEL 4
`define ICGC_BIT_INTON 3
`define ICGC_BIT_INTSTB 2
`define ICGC_BIT_EXTON 1
`define ICGC_BIT_EXTSTB 0
// ********************************************
// Reset values and limits
// ********************************************
`define ICGC_MULT_RESET 7'h15
`define ICGC_MULT_MIN 7'h01
`define ICGC_TRIM_RESET 8'h80
`define ICGC_DIV_MAX 4'h9
`define ICGC_STAB_CYCLES 4096
`define ICGC_READ_IDLE 8'h00
`endif

// ### hw/icgc_sync.v
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs are quasi-static levels from analog or pin sources.
`timescale 1ns/1ps
`default_nettype none
module icgc_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Levels in and out
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  // First stage, read only by the second stage
  reg [WIDTH-1:0] stageOne;

  // Both stages clear under reset
  always @(posedge mclk) begin
    if (!reset_n) begin
      stageOne <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end
endmodule
`default_nettype wire
